// *** rtl/ecm_pkg.sv ***
package ecm_pkg;

    // Reset and vector layout
    localparam logic [15:0] RESET_PC = 16'h0000;
    localparam logic [15:0] VEC_BASE = 16'hFF00;
    localparam int HW_IRQS = 4;
    localparam logic [7:0] SW_VEC_FIRST = 8'h10;
    localparam logic [7:0] SW_VEC_COUNT = 8'hF0;
    localparam logic [15:0] BUF_PTR_RESET = 16'h0000;
    localparam logic [15:0] BUF_SIZE_RESET = 16'h0000;
    localparam int NUM_REGS = 8;
    localparam logic [2:0] LINK_REG = 3'h6;

    // Instruction word fields
    localparam int OP_MSB = 15;
    localparam int OP_LSB = 12;
    localparam int MODE_MSB = 11;
    localparam int MODE_LSB = 9;
    localparam int DMEM_BIT = 8;
    localparam int RD_MSB = 7;
    localparam int RD_LSB = 5;
    localparam int RS_MSB = 4;
    localparam int RS_LSB = 2;
    localparam int DABS_BIT = 0;
    localparam int SHORT_MSB = 4;
    localparam int IEN_BIT = 2;

    typedef enum logic [3:0] {
        OP_MOV, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_CMP, OP_SHR,
        OP_MUL, OP_DIV, OP_JMP, OP_SWI, OP_RETI, OP_BUF, OP_IEN, OP_NOP
    } ecm_op_t;

    typedef enum logic [2:0] {
        MD_REG, MD_IMM, MD_DIR, MD_IND, MD_IDX, MD_AINC, MD_SHORT, MD_RSVD
    } ecm_mode_t;

    typedef enum logic [2:0] {
        CC_ALWAYS, CC_Z, CC_NZ, CC_N, CC_C, CC_V, CC_CALL, CC_NEVER
    } ecm_cond_t;

    typedef struct packed {
        logic prog;
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ecm_mem_req_t;

    typedef struct packed {
        logic z;
        logic n;
        logic c;
        logic v;
    } ecm_flags_t;

endpackage

// *** rtl/ecm_core.sv ***
`timescale 1ns/1ps
// How it works
// - Seven addressing modes give memory, register and immediate sources with register or memory targets.
// - Sources may be register, direct, immediate, indirect or indirect plus index word.
// - In auto-increment mode each pointer register steps by one after the access made through it.
// - Instructions are one 16-bit word, followed by up to two operand words that fetch consumes.
// - The short-immediate form carries a signed 5-bit constant inside the instruction word.
// - Move, logic, arithmetic, compare, shift, jump, call and return instructions are provided.
// - Signed multiply takes two 16-bit operands into a 32-bit product in a register pair.
// - Signed divide takes a 32-bit register-pair dividend and a 16-bit divisor.
// - A buffer instruction loads the packet buffer pointer or block size outputs.
// - Four prioritized vectored hardware interrupts and 240 software vectors are served.
module ecm_core (
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [15:0] MEM_RDATA_IN,
    input wire logic [3:0] IRQ_IN,
    output ecm_pkg::ecm_mem_req_t MEM_REQ_OUT,
    output logic [3:0] IRQ_ACK_OUT,
    output logic [15:0] BUF_PTR_OUT,
    output logic [15:0] BUF_SIZE_OUT,
    output logic BUF_LOAD_OUT,
    output logic DIV_ERR_OUT
);

    typedef enum logic [3:0] {
        ST_FETCH, ST_DEC, ST_PLAN, ST_EXT_A, ST_EXT_B, ST_ADDR,
        ST_SRC, ST_DADDR, ST_DST, ST_EXEC, ST_VEC, ST_VECW
    } ecm_state_t;

    ecm_state_t state_q;
    logic [15:0] pc_q, ir_q, ext_a_q, ext_b_q, src_q, dst_q, daddr_q, save_pc_q;
    logic [15:0] regs_q [ecm_pkg::NUM_REGS];
    ecm_pkg::ecm_flags_t flags_q, save_flags_q;
    logic ie_q;
    logic [7:0] vec_q;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    ecm_pkg::ecm_op_t op;
    ecm_pkg::ecm_mode_t mode;
    logic [2:0] rd, rs, rd_hi;
    logic dmem, dabs, data_op, src_ext, src_mem, need_dabs, mem_dst;

    assign op = ecm_pkg::ecm_op_t'(ir_q[ecm_pkg::OP_MSB:ecm_pkg::OP_LSB]);
    assign mode = ecm_pkg::ecm_mode_t'(ir_q[ecm_pkg::MODE_MSB:ecm_pkg::MODE_LSB]);
    assign rd = ir_q[ecm_pkg::RD_MSB:ecm_pkg::RD_LSB];
    assign rs = ir_q[ecm_pkg::RS_MSB:ecm_pkg::RS_LSB];
    assign rd_hi = rd + 3'h1;
    assign dmem = ir_q[ecm_pkg::DMEM_BIT];
    assign dabs = ir_q[ecm_pkg::DABS_BIT];
    assign data_op = (op <= ecm_pkg::OP_SHR);
    assign mem_dst = dmem && data_op;
    // Absolute target takes its own operand word, after the source word if there is one
    assign need_dabs = mem_dst && dabs;
    assign src_ext = (mode == ecm_pkg::MD_IMM) || (mode == ecm_pkg::MD_DIR) || (mode == ecm_pkg::MD_IDX);
    assign src_mem = (mode == ecm_pkg::MD_DIR) || (mode == ecm_pkg::MD_IND) ||
                     (mode == ecm_pkg::MD_IDX) || (mode == ecm_pkg::MD_AINC);

    ////////////////////////////////////////////////////////////////////////////
    // Execute datapath

    logic [16:0] sum;
    logic [15:0] res;
    logic signed [31:0] prod;
    logic signed [32:0] dvd, dvs, quo, rem;
    logic div_zero, div_ovf, take;
    ecm_pkg::ecm_flags_t alu_flags;

    always_comb begin
        sum = 17'h0_0000;
        res = 16'h0000;
        case (op)
            ecm_pkg::OP_MOV: res = src_q;
            ecm_pkg::OP_ADD: begin
                sum = {1'b0, dst_q} + {1'b0, src_q};
                res = sum[15:0];
            end
            ecm_pkg::OP_SUB, ecm_pkg::OP_CMP: begin
                sum = {1'b0, dst_q} - {1'b0, src_q};
                res = sum[15:0];
            end
            ecm_pkg::OP_AND: res = dst_q & src_q;
            ecm_pkg::OP_OR: res = dst_q | src_q;
            ecm_pkg::OP_XOR: res = dst_q ^ src_q;
            ecm_pkg::OP_SHR: res = dst_q >> src_q[3:0];
            default: res = 16'h0000;
        endcase
        alu_flags.z = (res == 16'h0000);
        alu_flags.n = res[15];
        alu_flags.c = sum[16];
        alu_flags.v = 1'b0;
        if (op == ecm_pkg::OP_ADD) begin
            alu_flags.v = (dst_q[15] == src_q[15]) && (res[15] != dst_q[15]);
        end else if (op == ecm_pkg::OP_SUB || op == ecm_pkg::OP_CMP) begin
            alu_flags.v = (dst_q[15] != src_q[15]) && (res[15] != dst_q[15]);
        end
    end

    assign prod = $signed(dst_q) * $signed(src_q);
    assign dvd = $signed({regs_q[rd_hi][15], regs_q[rd_hi], dst_q});
    assign div_zero = (src_q == 16'h0000);
    // Wider than the operands so that most-negative by -1 cannot wrap
    assign dvs = div_zero ? 33'sh0_0000_0001 : $signed({{17{src_q[15]}}, src_q});
    assign quo = dvd / dvs;
    assign rem = dvd % dvs;
    assign div_ovf = (quo[32:15] != {18{quo[15]}});

    always_comb begin
        case (ecm_pkg::ecm_cond_t'(rd))
            ecm_pkg::CC_ALWAYS, ecm_pkg::CC_CALL: take = 1'b1;
            ecm_pkg::CC_Z: take = flags_q.z;
            ecm_pkg::CC_NZ: take = !flags_q.z;
            ecm_pkg::CC_N: take = flags_q.n;
            ecm_pkg::CC_C: take = flags_q.c;
            ecm_pkg::CC_V: take = flags_q.v;
            default: take = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer, memory requests and interrupts

    logic irq_any;
    logic [1:0] irq_idx;
    logic [7:0] swi_num;

    assign irq_any = ie_q && (IRQ_IN != 4'h0);
    assign irq_idx = IRQ_IN[0] ? 2'd0 : IRQ_IN[1] ? 2'd1 : IRQ_IN[2] ? 2'd2 : 2'd3;
    assign swi_num = ir_q[7:0];

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            state_q <= ST_FETCH;
            pc_q <= ecm_pkg::RESET_PC;
            ir_q <= 16'h0000;
            ext_a_q <= 16'h0000;
            ext_b_q <= 16'h0000;
            vec_q <= 8'h00;
            MEM_REQ_OUT <= '0;
            IRQ_ACK_OUT <= 4'h0;
        end else begin
            MEM_REQ_OUT.rd <= 1'b0;
            MEM_REQ_OUT.wr <= 1'b0;
            IRQ_ACK_OUT <= 4'h0;
            case (state_q)
                ST_FETCH: begin
                    if (irq_any) begin
                        // Lowest line wins; acknowledge so the source can drop its level
                        vec_q <= {6'h00, irq_idx};
                        IRQ_ACK_OUT <= 4'h1 << irq_idx;
                        state_q <= ST_VEC;
                    end else begin
                        MEM_REQ_OUT <= '{prog: 1'b1, rd: 1'b1, wr: 1'b0, addr: pc_q, wdata: 16'h0000};
                        pc_q <= pc_q + 16'h0001;
                        state_q <= ST_DEC;
                    end
                end
                ST_DEC: begin
                    ir_q <= MEM_RDATA_IN;
                    state_q <= ST_PLAN;
                end
                ST_PLAN: begin
                    if (src_ext || need_dabs) begin
                        MEM_REQ_OUT <= '{prog: 1'b1, rd: 1'b1, wr: 1'b0, addr: pc_q, wdata: 16'h0000};
                        pc_q <= pc_q + 16'h0001;
                        state_q <= src_ext ? ST_EXT_A : ST_EXT_B;
                    end else begin
                        state_q <= ST_ADDR;
                    end
                end
                ST_EXT_A: begin
                    ext_a_q <= MEM_RDATA_IN;
                    if (need_dabs) begin
                        MEM_REQ_OUT <= '{prog: 1'b1, rd: 1'b1, wr: 1'b0, addr: pc_q, wdata: 16'h0000};
                        pc_q <= pc_q + 16'h0001;
                        state_q <= ST_EXT_B;
                    end else begin
                        state_q <= ST_ADDR;
                    end
                end
                ST_EXT_B: begin
                    ext_b_q <= MEM_RDATA_IN;
                    state_q <= ST_ADDR;
                end
                ST_ADDR: begin
                    if (src_mem) begin
                        MEM_REQ_OUT.prog <= 1'b0;
                        MEM_REQ_OUT.rd <= 1'b1;
                        case (mode)
                            ecm_pkg::MD_DIR: MEM_REQ_OUT.addr <= ext_a_q;
                            ecm_pkg::MD_IDX: MEM_REQ_OUT.addr <= regs_q[rs] + ext_a_q;
                            default: MEM_REQ_OUT.addr <= regs_q[rs];
                        endcase
                        state_q <= ST_SRC;
                    end else begin
                        state_q <= ST_DADDR;
                    end
                end
                ST_SRC: state_q <= ST_DADDR;
                ST_DADDR: begin
                    // Read-modify-write targets fetch the old value first
                    if (mem_dst && op != ecm_pkg::OP_MOV) begin
                        MEM_REQ_OUT.prog <= 1'b0;
                        MEM_REQ_OUT.rd <= 1'b1;
                        MEM_REQ_OUT.addr <= dabs ? ext_b_q : regs_q[rd];
                        state_q <= ST_DST;
                    end else begin
                        state_q <= ST_EXEC;
                    end
                end
                ST_DST: state_q <= ST_EXEC;
                ST_EXEC: begin
                    state_q <= ST_FETCH;
                    if (mem_dst && op != ecm_pkg::OP_CMP) begin
                        MEM_REQ_OUT <= '{prog: 1'b0, rd: 1'b0, wr: 1'b1, addr: daddr_q, wdata: res};
                    end
                    case (op)
                        ecm_pkg::OP_JMP: if (take) pc_q <= src_q;
                        ecm_pkg::OP_RETI: pc_q <= save_pc_q;
                        ecm_pkg::OP_SWI: begin
                            // Numbers past the last software vector execute as no-ops
                            if (swi_num < ecm_pkg::SW_VEC_COUNT) begin
                                vec_q <= swi_num + ecm_pkg::SW_VEC_FIRST;
                                state_q <= ST_VEC;
                            end
                        end
                        default: ;
                    endcase
                end
                ST_VEC: begin
                    MEM_REQ_OUT <= '{prog: 1'b1, rd: 1'b1, wr: 1'b0,
                                     addr: ecm_pkg::VEC_BASE + {8'h00, vec_q}, wdata: 16'h0000};
                    state_q <= ST_VECW;
                end
                ST_VECW: begin
                    pc_q <= MEM_RDATA_IN;
                    state_q <= ST_FETCH;
                end
                default: state_q <= ST_FETCH;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operands, register file and status

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            src_q <= 16'h0000;
            dst_q <= 16'h0000;
            daddr_q <= 16'h0000;
            for (int i = 0; i < ecm_pkg::NUM_REGS; i++) begin
                regs_q[i] <= 16'h0000;
            end
        end else begin
            case (state_q)
                ST_ADDR: begin
                    if (mode == ecm_pkg::MD_AINC) begin
                        regs_q[rs] <= regs_q[rs] + 16'h0001;
                    end
                    case (mode)
                        ecm_pkg::MD_REG: src_q <= regs_q[rs];
                        ecm_pkg::MD_IMM: src_q <= ext_a_q;
                        // Short form: sign-extended constant from the low five instruction bits
                        ecm_pkg::MD_SHORT: src_q <= {{11{ir_q[ecm_pkg::SHORT_MSB]}},
                                                     ir_q[ecm_pkg::SHORT_MSB:0]};
                        default: src_q <= src_q;
                    endcase
                end
                ST_SRC: src_q <= MEM_RDATA_IN;
                ST_DADDR: begin
                    daddr_q <= dabs ? ext_b_q : regs_q[rd];
                    dst_q <= regs_q[rd];
                    if (mem_dst && !dabs && mode == ecm_pkg::MD_AINC) begin
                        regs_q[rd] <= regs_q[rd] + 16'h0001;
                    end
                end
                ST_DST: dst_q <= MEM_RDATA_IN;
                ST_EXEC: begin
                    case (op)
                        ecm_pkg::OP_MUL: begin
                            regs_q[rd] <= prod[15:0];
                            regs_q[rd_hi] <= prod[31:16];
                        end
                        ecm_pkg::OP_DIV: begin
                            if (!div_zero && !div_ovf) begin
                                regs_q[rd] <= quo[15:0];
                                regs_q[rd_hi] <= rem[15:0];
                            end
                        end
                        ecm_pkg::OP_JMP: begin
                            if (ecm_pkg::ecm_cond_t'(rd) == ecm_pkg::CC_CALL) begin
                                regs_q[ecm_pkg::LINK_REG] <= pc_q;
                            end
                        end
                        default: begin
                            if (data_op && !dmem && op != ecm_pkg::OP_CMP) begin
                                regs_q[rd] <= res;
                            end
                        end
                    endcase
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            flags_q <= '0;
            save_flags_q <= '0;
            save_pc_q <= 16'h0000;
            ie_q <= 1'b0;
            DIV_ERR_OUT <= 1'b0;
        end else begin
            if (state_q == ST_VEC) begin
                // Single level: entry masks further interrupts until return
                save_pc_q <= pc_q;
                save_flags_q <= flags_q;
                ie_q <= 1'b0;
            end else if (state_q == ST_EXEC) begin
                case (op)
                    ecm_pkg::OP_MUL: flags_q <= '{z: (prod == 32'sh0000_0000), n: prod[31], c: 1'b0, v: 1'b0};
                    ecm_pkg::OP_DIV: begin
                        flags_q.v <= div_zero || div_ovf;
                        DIV_ERR_OUT <= div_zero || div_ovf;
                    end
                    ecm_pkg::OP_RETI: begin
                        flags_q <= save_flags_q;
                        ie_q <= 1'b1;
                    end
                    ecm_pkg::OP_IEN: ie_q <= ir_q[ecm_pkg::IEN_BIT];
                    default: if (data_op) flags_q <= alu_flags;
                endcase
            end
        end
    end

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            BUF_PTR_OUT <= ecm_pkg::BUF_PTR_RESET;
            BUF_SIZE_OUT <= ecm_pkg::BUF_SIZE_RESET;
            BUF_LOAD_OUT <= 1'b0;
        end else begin
            BUF_LOAD_OUT <= 1'b0;
            if (state_q == ST_EXEC && op == ecm_pkg::OP_BUF) begin
                BUF_LOAD_OUT <= 1'b1;
                if (rd[0]) begin
                    BUF_SIZE_OUT <= src_q;
                end else begin
                    BUF_PTR_OUT <= src_q;
                end
            end
        end
    end

endmodule

// *** verif/ecm_core_props.sv ***
`timescale 1ns/1ps
module ecm_core_props (
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [15:0] MEM_RDATA_IN,
    input wire logic [3:0] IRQ_IN,
    input ecm_pkg::ecm_mem_req_t MEM_REQ_OUT,
    input wire logic [3:0] IRQ_ACK_OUT,
    input wire logic [15:0] BUF_PTR_OUT,
    input wire logic [15:0] BUF_SIZE_OUT,
    input wire logic BUF_LOAD_OUT,
    input wire logic DIV_ERR_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    property p_first_fetch;
        $past(SYS_RST_IN) |-> ##[0:2] (MEM_REQ_OUT.rd && MEM_REQ_OUT.prog && MEM_REQ_OUT.addr == ecm_pkg::RESET_PC);
    endproperty
    a_first_fetch: assert property (p_first_fetch) else $error("first fetch not at reset address");
    property p_rd_wr_apart;
        !(MEM_REQ_OUT.rd && MEM_REQ_OUT.wr);
    endproperty
    a_rd_wr_apart: assert property (p_rd_wr_apart) else $error("read and write in one cycle");
    property p_wr_data_space;
        MEM_REQ_OUT.wr |-> !MEM_REQ_OUT.prog;
    endproperty
    a_wr_data_space: assert property (p_wr_data_space) else $error("write to program space");
    property p_buf_load_after_change;
        ($changed(BUF_PTR_OUT) || $changed(BUF_SIZE_OUT)) |-> ##[0:1] BUF_LOAD_OUT;
    endproperty
    a_buf_load_after_change: assert property (p_buf_load_after_change) else $error("buffer change without load");
    property p_buf_load_pulse;
        BUF_LOAD_OUT |=> !BUF_LOAD_OUT;
    endproperty
    a_buf_load_pulse: assert property (p_buf_load_pulse) else $error("buffer load longer than one cycle");
    property p_ack_onehot;
        $onehot0(IRQ_ACK_OUT) && (IRQ_ACK_OUT == 4'h0 || $past(IRQ_ACK_OUT) == 4'h0);
    endproperty
    a_ack_onehot: assert property (p_ack_onehot) else $error("acknowledge not a one-hot pulse");
    property p_ack_priority;
        (IRQ_ACK_OUT != 4'h0) |-> ((IRQ_ACK_OUT & $past(IRQ_IN)) != 4'h0 && ((IRQ_ACK_OUT - 4'h1) & $past(IRQ_IN)) == 4'h0);
    endproperty
    a_ack_priority: assert property (p_ack_priority) else $error("acknowledge ignores priority");
    property p_ack_vector_read;
        (IRQ_ACK_OUT != 4'h0) |-> ##[0:3] (MEM_REQ_OUT.rd && MEM_REQ_OUT.prog
            && MEM_REQ_OUT.addr[15:2] == ecm_pkg::VEC_BASE[15:2]);
    endproperty
    a_ack_vector_read: assert property (p_ack_vector_read) else $error("no vector read after acknowledge");
endmodule

bind ecm_core ecm_core_props ecm_core_props_inst (.MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .MEM_RDATA_IN(MEM_RDATA_IN), .IRQ_IN(IRQ_IN), .MEM_REQ_OUT(MEM_REQ_OUT), .IRQ_ACK_OUT(IRQ_ACK_OUT),
    .BUF_PTR_OUT(BUF_PTR_OUT), .BUF_SIZE_OUT(BUF_SIZE_OUT), .BUF_LOAD_OUT(BUF_LOAD_OUT), .DIV_ERR_OUT(DIV_ERR_OUT));

// *** verif/ecm_mem_model.sv ***
`timescale 1ns/1ps
module ecm_mem_model (
    input wire logic clk_in,
    input ecm_pkg::ecm_mem_req_t req_in,
    output logic [15:0] rdata_out
);
    logic [15:0] pmem [0:65535];
    logic [15:0] dmem [0:65535];
    logic [15:0] held_q;

    // Async read, no wait states; idle bus shows inverse of last word, not a stale copy
    assign rdata_out = req_in.rd ? (req_in.prog ? pmem[req_in.addr] : dmem[req_in.addr]) : ~held_q;

    // Plain always: the bench preloads both arrays directly
    always @(posedge clk_in) begin
        if (req_in.rd) begin
            held_q <= rdata_out;
        end
        if (req_in.wr && req_in.prog) begin
            pmem[req_in.addr] <= req_in.wdata;
        end else if (req_in.wr) begin
            dmem[req_in.addr] <= req_in.wdata;
        end
    end
endmodule

// *** verif/embedded_cpu_muldiv_core_bench.sv ***
`timescale 1ns/1ps
module embedded_cpu_muldiv_core_bench;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] irq = 4'h0;
    logic [15:0] rdata;
    ecm_pkg::ecm_mem_req_t req;
    logic [3:0] irq_ack;
    logic [15:0] buf_ptr;
    logic [15:0] buf_size;
    logic buf_load;
    logic div_err;
    int n_fail = 0;
    int n_compared = 0;
    int pc_w;
    int n_load = 0;

    always #20 mclk = ~mclk;

    // Mid-cycle sampling counts each one-cycle pulse exactly once
    always @(negedge mclk) begin
        if (buf_load === 1'b1) begin
            n_load++;
        end
    end

    ecm_core ecm_core_inst (.MCLK_IN(mclk), .SYS_RST_IN(sys_rst), .MEM_RDATA_IN(rdata), .IRQ_IN(irq),
        .MEM_REQ_OUT(req), .IRQ_ACK_OUT(irq_ack), .BUF_PTR_OUT(buf_ptr), .BUF_SIZE_OUT(buf_size),
        .BUF_LOAD_OUT(buf_load), .DIV_ERR_OUT(div_err));
    ecm_mem_model ecm_mem_model_inst (.clk_in(mclk), .req_in(req), .rdata_out(rdata));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] ins(input logic [3:0] op, input logic [2:0] md, input logic dm,
        input logic [2:0] rd, input logic [4:0] lo);
        return {op, md, dm, rd, lo};
    endfunction

    task automatic put(input logic [15:0] w);
        ecm_mem_model_inst.pmem[pc_w] = w;
        pc_w++;
    endtask

    // Store register to absolute data address
    task automatic st(input logic [2:0] r, input logic [15:0] a);
        put(ins(4'h0, 3'd0, 1'b1, 3'd0, {r, 2'b01}));
        put(a);
    endtask

    task automatic halt();
        int j;
        j = pc_w;
        put(ins(4'hA, 3'd1, 1'b0, 3'd0, 5'h00));
        put(j[15:0]);
    endtask

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        #1 sys_rst = 1'b1;
        repeat (6) @(posedge mclk);
        #1 sys_rst = 1'b0;
    endtask

    task automatic report_and_stop();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Arithmetic, addressing, buffer setup and divide error in one program
    task automatic test_datapath();
        int k;
        int ret;
        pc_w = 0;
        ecm_mem_model_inst.dmem[16'h0110] = 16'h1000;
        ecm_mem_model_inst.dmem[16'h0111] = 16'h0234;
        ecm_mem_model_inst.dmem[16'h0112] = 16'h0001;
        put(ins(4'h0, 3'd1, 1'b0, 3'd1, 5'h00)); put(16'h1234);
        put(ins(4'h1, 3'd6, 1'b0, 3'd1, 5'h03));
        st(3'd1, 16'h0100);
        put(ins(4'h0, 3'd6, 1'b0, 3'd2, 5'h1D));
        put(ins(4'h8, 3'd1, 1'b0, 3'd2, 5'h00)); put(16'h0007);
        st(3'd2, 16'h0101); st(3'd3, 16'h0102);
        put(ins(4'h9, 3'd1, 1'b0, 3'd2, 5'h00)); put(16'h0004);
        st(3'd2, 16'h0103); st(3'd3, 16'h0104);
        put(ins(4'h0, 3'd1, 1'b0, 3'd4, 5'h00)); put(16'h0110);
        put(ins(4'h0, 3'd5, 1'b0, 3'd5, 5'h10));
        put(ins(4'h1, 3'd5, 1'b0, 3'd5, 5'h10));
        st(3'd5, 16'h0105); st(3'd4, 16'h0106);
        put(ins(4'h0, 3'd4, 1'b0, 3'd6, 5'h10)); put(16'hFFFE);
        put(ins(4'h0, 3'd2, 1'b0, 3'd7, 5'h00)); put(16'h0111);
        put(ins(4'h1, 3'd3, 1'b0, 3'd7, 5'h10));
        st(3'd6, 16'h0107); st(3'd7, 16'h0108);
        // Logic, shift and read-modify-write to an absolute target
        put(ins(4'h2, 3'd0, 1'b0, 3'd5, 5'h18));
        put(ins(4'h3, 3'd1, 1'b0, 3'd5, 5'h00)); put(16'h00FF);
        put(ins(4'h4, 3'd6, 1'b0, 3'd5, 5'h03));
        put(ins(4'h5, 3'd1, 1'b0, 3'd5, 5'h00)); put(16'h0F00);
        put(ins(4'h7, 3'd6, 1'b0, 3'd5, 5'h04));
        st(3'd5, 16'h0109);
        put(ins(4'h1, 3'd6, 1'b1, 3'd0, 5'h05)); put(16'h0109);
        // Compare, taken and untaken branches, call with link
        put(ins(4'h6, 3'd1, 1'b0, 3'd1, 5'h00)); put(16'h1237);
        put(ins(4'hA, 3'd1, 1'b0, 3'd1, 5'h00)); put(pc_w[15:0] + 16'h0002);
        put(ins(4'h0, 3'd6, 1'b0, 3'd1, 5'h00));
        put(ins(4'hA, 3'd1, 1'b0, 3'd2, 5'h00)); put(pc_w[15:0] + 16'h0002);
        put(ins(4'h0, 3'd6, 1'b0, 3'd7, 5'h01));
        put(ins(4'hA, 3'd1, 1'b0, 3'd6, 5'h00));
        ret = pc_w + 1;
        put(pc_w[15:0] + 16'h0002);
        put(ins(4'h0, 3'd6, 1'b0, 3'd7, 5'h00));
        st(3'd1, 16'h010A); st(3'd7, 16'h010B); st(3'd6, 16'h010C);
        put(ins(4'hD, 3'd1, 1'b0, 3'd0, 5'h00)); put(16'h0200);
        put(ins(4'hD, 3'd6, 1'b0, 3'd1, 5'h0F));
        put(ins(4'h9, 3'd6, 1'b0, 3'd2, 5'h00));
        halt();
        do_reset();
        k = 0;
        while (div_err !== 1'b1 && k < 2000) begin
            @(posedge mclk);
            k++;
        end
        repeat (4) @(posedge mclk);
        check16(ecm_mem_model_inst.dmem[16'h0100], 16'h1237);
        check16(ecm_mem_model_inst.dmem[16'h0101], 16'hFFEB);
        check16(ecm_mem_model_inst.dmem[16'h0102], 16'hFFFF);
        check16(ecm_mem_model_inst.dmem[16'h0103], 16'hFFFB);
        check16(ecm_mem_model_inst.dmem[16'h0104], 16'hFFFF);
        check16(ecm_mem_model_inst.dmem[16'h0105], 16'h1234);
        check16(ecm_mem_model_inst.dmem[16'h0106], 16'h0112);
        check16(ecm_mem_model_inst.dmem[16'h0107], 16'h1000);
        check16(ecm_mem_model_inst.dmem[16'h0108], 16'h0235);
        check16(buf_ptr, 16'h0200);
        check16(buf_size, 16'h000F);
        check16({15'h0000, div_err}, 16'h0001);
        check16(ecm_mem_model_inst.dmem[16'h0109], 16'h00F8);
        check16(ecm_mem_model_inst.dmem[16'h010A], 16'h1237);
        check16(ecm_mem_model_inst.dmem[16'h010B], 16'h0001);
        check16(ecm_mem_model_inst.dmem[16'h010C], ret[15:0]);
        check16(n_load[15:0], 16'h0002);
    endtask

    // Software vectors, reserved number, hardware priority and immediate-to-memory
    task automatic test_interrupts();
        int k;
        pc_w = 0;
        put(16'hB0F0);
        put(16'hB000);
        put(16'hE004);
        halt();
        ecm_mem_model_inst.pmem[16'hFF10] = 16'h0040;
        ecm_mem_model_inst.pmem[16'hFF00] = 16'h0050;
        pc_w = 16'h0040;
        put(ins(4'h0, 3'd1, 1'b1, 3'd0, 5'h01)); put(16'h005A); put(16'h0121);
        put(16'hC000);
        pc_w = 16'h0050;
        put(ins(4'h0, 3'd1, 1'b1, 3'd0, 5'h01)); put(16'h00A5); put(16'h0120);
        halt();
        do_reset();
        repeat (200) @(posedge mclk);
        check16(ecm_mem_model_inst.dmem[16'h0121], 16'h005A);
        #1 irq = 4'b0101;
        k = 0;
        // Acknowledge stands one cycle: look at it mid-cycle
        while (irq_ack === 4'h0 && k < 200) begin
            @(negedge mclk);
            k++;
        end
        check16({12'h000, irq_ack}, 16'h0001);
        @(posedge mclk);
        #1 irq = 4'h0;
        repeat (100) @(posedge mclk);
        check16(ecm_mem_model_inst.dmem[16'h0120], 16'h00A5);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        test_datapath();
        test_interrupts();
        report_and_stop();
    end

    // Both programs finish in well under a thousand cycles each
    initial begin
        #(40 * 6000);
        n_fail++;
        report_and_stop();
    end
endmodule
